/* dv/testbench.sv */
/* Self-checking bench for the video DRAM host controller.
   Assumes: vdc_dev_model on the pins, register port driven here. */
`timescale 1ns/100ps
`include "vdc_regs.vh"
module testbench;
   logic        mclk, sys_rst, wr_stb, rd_stb;
   logic [3:0]  addr;
   logic [31:0] wr_data, d;
   wire  [31:0] rd_data_q;
   wire  [8:0]  dram_addr;
   wire  [15:0] dq_out, dq_in, sio_out, sio_in;
   wire         row_n, col_n, we_n, oe_n, sel, dq_oe, sclk, sen_n, sio_oe;
   logic [8:0]  row, col;
   logic [15:0] wd;
   int          err_count, checks, i, n, f0, exp_p;
   vdc_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q), .row_strobe_n_q(row_n),
      .col_strobe_n_q(col_n), .dram_addr_q(dram_addr), .bitmask_write_enable_n_q(we_n),
      .transfer_output_enable_n_q(oe_n), .special_function_select_q(sel),
      .random_data_pins_out_q(dq_out), .random_data_pins_oe_q(dq_oe),
      .random_data_pins_in(dq_in), .serial_shift_clock_q(sclk),
      .serial_port_enable_n_q(sen_n), .serial_data_pins_out_q(sio_out),
      .serial_data_pins_oe_q(sio_oe), .serial_data_pins_in(sio_in));
   vdc_dev_model u_dev (.row_n(row_n), .col_n(col_n), .adr(dram_addr), .we_n(we_n),
      .oe_n(oe_n), .sel(sel), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
      .sclk(sclk), .sen_n(sen_n), .sio_oe(sio_oe), .sio_in(sio_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask
   // Bus cycles: one strobe cycle, read data taken in the next cycle
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wr_data <= v;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rd_data_q;
   endtask
   // Start one random-port cycle and poll busy under a bound
   task automatic run(input logic [2:0] c, input logic late);
      int k;
      wr(`VDC_OFF_ROW, {23'h0, row});
      wr(`VDC_OFF_COL, {23'h0, col});
      wr(`VDC_OFF_WDATA, {16'h0, wd});
      wr(`VDC_OFF_CMD, {27'h0, late, 1'b1, c});
      k = 0;
      d = 32'h1;
      while (d[0] !== 1'b0 && k < 60) begin
         rd(`VDC_OFF_STATUS);
         k++;
      end
      if (k == 60) begin
         err_count++;
         report_and_stop();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      report_and_stop();
   end
   initial begin
      sys_rst = 1'b1;
      {wr_stb, rd_stb, addr, wr_data, err_count, checks} = '0;
      void'($urandom(73));
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      wr(`VDC_OFF_SCTL, 32'h100);
      // Cycle kinds 0 to 5 with random row, column and data
      for (i = 0; i < 6; i++) begin
         row = 9'($urandom);
         col = 9'($urandom);
         wd = 16'($urandom);
         f0 = u_dev.nfall;
         run(3'(i), 1'($urandom));
         chk(u_dev.nfall - f0, 1);
         chk(u_dev.sel_at_row, (i == 1 || i == 2 || i == 4));
         chk(u_dev.cbr_at_row, (i == 2 || i == 3));
         if (i < 2 || i > 3) chk(u_dev.row_addr, row);
         if (i < 2) begin
            chk(u_dev.dq_seen, wd);
            rd(`VDC_OFF_WDATA);
            chk(d, {16'h0, ~wd});
         end
      end
      // New-mask cycle refused on the oldest revision only
      wr(`VDC_OFF_SCTL, 32'h0);
      f0 = u_dev.nfall;
      run(3'd6, 1'b0);
      chk(d[1], 1);
      chk(u_dev.nfall - f0, 0);
      wr(`VDC_OFF_SCTL, 32'h100);
      run(3'd6, 1'b0);
      chk(u_dev.nfall - f0, 1);
      // Transfer near the top, then serial read across the wrap
      wr(`VDC_OFF_SSTART, 32'h1fc);
      run(3'd7, 1'b0);
      chk(u_dev.start, 9'h1fc);
      n = u_dev.nrise;
      wr(`VDC_OFF_SCTL, 32'h110);
      f0 = u_dev.nfall;
      run(3'd0, 1'b0);
      chk(u_dev.nfall - f0, 1);
      repeat (60) @(posedge mclk);
      wr(`VDC_OFF_SCTL, 32'h100);
      repeat (20) @(posedge mclk);
      // Last word read is the pointer before the final shift
      exp_p = 'h1fc;
      for (i = 1; i < u_dev.nrise - n; i++) exp_p = (exp_p == 511) ? 'h1fc : exp_p + 1;
      rd(`VDC_OFF_SDATA);
      chk(d, exp_p);
      exp_p = (exp_p == 511) ? 'h1fc : exp_p + 1;
      rd(`VDC_OFF_STATUS);
      chk(d[15:7], exp_p);
      chk(u_dev.nrise - n > 4, 1);
      // Split transfer with the pointer on the jump source and in the split half
      wr(`VDC_OFF_RESTR, exp_p);
      wr(`VDC_OFF_SCTL, 32'h10e);
      wr(`VDC_OFF_CMD, {27'h0, 2'b01, 3'd7});
      rd(`VDC_OFF_STATUS);
      rd(`VDC_OFF_STATUS);
      chk(d[2], 1);
      repeat (20) @(posedge mclk);
      rd(`VDC_OFF_STATUS);
      chk(d[2:0], 0);
      // Unmapped write leaves the controller idle
      wr(4'hf, 32'hffff_ffff);
      rd(`VDC_OFF_STATUS);
      chk(d[0], 0);
      report_and_stop();
   end
endmodule

/* dv/vdc_ctrl_props.sv */
/* Port checker for the video DRAM host controller.
   Assumes: bound to vdc_ctrl; one clock mclk, sync reset sys_rst. */
`timescale 1ns/100ps
module vdc_ctrl_props #(
   parameter PHASE = 3,
   parameter WIDE  = 1
) (
   input wire        mclk,
   input wire        sys_rst,
   input wire        rd_stb,
   input wire [31:0] rd_data_q,
   input wire        row_strobe_n_q,
   input wire        col_strobe_n_q,
   input wire [8:0]  dram_addr_q,
   input wire        bitmask_write_enable_n_q,
   input wire        transfer_output_enable_n_q,
   input wire        special_function_select_q,
   input wire        random_data_pins_oe_q,
   input wire        serial_shift_clock_q,
   input wire        serial_data_pins_oe_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////////
   // Controls settle before the row strobe falls
   AST_CTRL_SETUP: assert property ($fell(row_strobe_n_q) |->
      $stable(special_function_select_q) && $stable(bitmask_write_enable_n_q)
      && $stable(transfer_output_enable_n_q)) else $error("controls moved at row fall");
   AST_ROW_ADDR: assert property ($fell(row_strobe_n_q) |-> $stable(dram_addr_q))
      else $error("row address moved at row fall");
   AST_ROW_HOLD: assert property ($fell(row_strobe_n_q) |-> !row_strobe_n_q[*3])
      else $error("row strobe low too short");
   AST_COL_HOLD: assert property ($fell(col_strobe_n_q) |-> !col_strobe_n_q[*3])
      else $error("column strobe low too short");
   AST_SEL_QUIET: assert property ($changed(special_function_select_q) |-> row_strobe_n_q)
      else $error("select changed inside a cycle");
   AST_WR_DRIVE: assert property (random_data_pins_oe_q |-> !row_strobe_n_q)
      else $error("data driven outside a cycle");
   AST_SER_HIGH: assert property ($rose(serial_shift_clock_q) |->
      serial_shift_clock_q[*4] ##1 !serial_shift_clock_q) else $error("serial clock high time");
   // Read data stays put between reads
   AST_RD_HOLD: assert property (!rd_stb |=> $stable(rd_data_q))
      else $error("read data changed without read");
   // Reset parks every strobe and driver
   AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst |=> row_strobe_n_q
      && col_strobe_n_q && !random_data_pins_oe_q && !serial_data_pins_oe_q
      && !serial_shift_clock_q) else $error("outputs not idle after reset");
   cover property ($fell(row_strobe_n_q) && special_function_select_q);
   cover property ($fell(row_strobe_n_q) && !col_strobe_n_q);
   cover property ($rose(serial_shift_clock_q) && !row_strobe_n_q);
endmodule
bind vdc_ctrl vdc_ctrl_props #(.PHASE(PHASE), .WIDE(WIDE)) u_props (.mclk(mclk),
   .sys_rst(sys_rst), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
   .row_strobe_n_q(row_strobe_n_q), .col_strobe_n_q(col_strobe_n_q),
   .dram_addr_q(dram_addr_q), .bitmask_write_enable_n_q(bitmask_write_enable_n_q),
   .transfer_output_enable_n_q(transfer_output_enable_n_q),
   .special_function_select_q(special_function_select_q),
   .random_data_pins_oe_q(random_data_pins_oe_q),
   .serial_shift_clock_q(serial_shift_clock_q), .serial_data_pins_oe_q(serial_data_pins_oe_q));

/* dv/vdc_dev_model.sv */
/* Behavioural dual-port video DRAM seen from its pins.
   Assumes: driven by vdc_ctrl; no clock of its own, strobe timed. */
`timescale 1ns/100ps
module vdc_dev_model (
   input  wire        row_n,
   input  wire        col_n,
   input  wire [8:0]  adr,
   input  wire        we_n,
   input  wire        oe_n,
   input  wire        sel,
   input  wire [15:0] dq_out,
   input  wire        dq_oe,
   output wire [15:0] dq_in,
   input  wire        sclk,
   input  wire        sen_n,
   input  wire        sio_oe,
   output wire [15:0] sio_in
);
   logic        sel_at_row = 1'b0;
   logic        cbr_at_row = 1'b0;
   logic        xfer = 1'b0;
   logic [8:0]  row_addr = 9'h000;
   logic [8:0]  start = 9'h000;
   logic [8:0]  ptr = 9'h000;
   logic [15:0] dq_seen = 16'h0000;
   int          nfall = 0;
   int          nrise = 0;
   ////////////////////////////////////////////////////////////////////////////
   // cycle kind taken at row strobe fall
   // row address doubles as refresh row
   always @(negedge row_n) begin
      sel_at_row = sel;
      cbr_at_row = !col_n;
      xfer = !oe_n;
      row_addr = adr;
      nfall++;
   end
   // column select or write data, early or late write
   always @(negedge col_n or negedge we_n) begin
      if (!row_n && !col_n && !we_n && dq_oe) dq_seen = dq_out;
   end
   // transfer sets the serial start address
   always @(negedge col_n) begin
      if (!row_n && xfer) begin
         start = adr;
         ptr = adr;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // serial side runs alone, no boundary jump
   always @(posedge sclk) begin
      if (sen_n === 1'b0) begin
         nrise++;
         ptr = (ptr == 9'h1ff) ? start : ptr + 9'h001;
      end
   end
   // Released lines show inverted data, never a stale copy
   assign sio_in = (!sen_n && !sio_oe) ? {7'h00, ptr} : ~{7'h00, ptr};
   assign dq_in = ~dq_seen;
endmodule

/* inc/vdc_regs.vh */
/*
 File: constants for the dual-port video DRAM host controller.
 Assumes: included by verilog/vdc_ctrl.v and verilog/vdc_serial.v.
*/
`ifndef VDC_REGS_VH
`define VDC_REGS_VH
// Register port offsets
`define VDC_OFF_CMD      4'h0
`define VDC_OFF_ROW      4'h1
`define VDC_OFF_COL      4'h2
`define VDC_OFF_WDATA    4'h3
`define VDC_OFF_STATUS   4'h4
`define VDC_OFF_SCTL     4'h5
`define VDC_OFF_SSTART   4'h6
`define VDC_OFF_SDATA    4'h7
`define VDC_OFF_RESTR    4'h8
// Cycle kinds in the command register
`define VDC_CYC_WRITE    3'h0
`define VDC_CYC_BLKWR    3'h1
`define VDC_CYC_HREF_NR  3'h2
`define VDC_CYC_HREF_RS  3'h3
`define VDC_CYC_SET_COL  3'h4
`define VDC_CYC_SET_MSK  3'h5
`define VDC_CYC_NEWMASK  3'h6
`define VDC_CYC_XFER     3'h7
// Command register fields
`define VDC_CMD_GO       3
`define VDC_CMD_LATE     4
// Serial control fields
`define VDC_SCTL_DIR     0
`define VDC_SCTL_HALF    1
`define VDC_SCTL_SPLIT   2
`define VDC_SCTL_REVE    3
`define VDC_SCTL_RUN     4
// Revision codes for the attached part
`define VDC_REV_A        2'h0
`define VDC_REV_F        2'h1
`define VDC_REV_E        2'h2
// Strobe phase timing: 30 ns each phase at 10 ns
`define VDC_T_PHASE_NS   30
`define VDC_CLK_NS       10
`define VDC_PHASE_CYC    ((`VDC_T_PHASE_NS + `VDC_CLK_NS - 1) / `VDC_CLK_NS)
`define VDC_SDIV         4
`define VDC_LAST_256     9'h0ff
`define VDC_LAST_512     9'h1ff
`endif

/* verilog/vdc_ctrl.v */
/*
 File: host controller for a dual-port video DRAM, random and serial sides.
 Assumes: one clock mclk at 100 MHz; software uses the plain register port.
*/
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "vdc_regs.vh"
module vdc_ctrl #(
   parameter PHASE = `VDC_PHASE_CYC,
   parameter WIDE  = 1
) (
   input  wire        mclk,
   input  wire        sys_rst,
   input  wire [3:0]  addr,
   input  wire [31:0] wr_data,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [31:0] rd_data_q,
   output reg         row_strobe_n_q,
   output reg         col_strobe_n_q,
   output reg  [8:0]  dram_addr_q,
   output reg         bitmask_write_enable_n_q,
   output reg         transfer_output_enable_n_q,
   output reg         special_function_select_q,
   output reg  [15:0] random_data_pins_out_q,
   output reg         random_data_pins_oe_q,
   input  wire [15:0] random_data_pins_in,
   output wire        serial_shift_clock_q,
   output wire        serial_port_enable_n_q,
   output wire [15:0] serial_data_pins_out_q,
   output wire        serial_data_pins_oe_q,
   input  wire [15:0] serial_data_pins_in
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SETUP = 3'h1;
   localparam ST_ROW = 3'h2;
   localparam ST_COL = 3'h3;
   localparam ST_DONE = 3'h4;

   reg [2:0]  state_q;
   reg [7:0]  cnt_q;
   reg [2:0]  cyc_q;
   reg        late_q;
   reg        busy_q;
   reg        refused_q;
   reg [8:0]  row_q;
   reg [8:0]  col_q;
   reg [15:0] wdat_q;
   reg [15:0] rdat_q;
   reg [1:0]  rev_q;
   reg [4:0]  sctl_q;
   reg [8:0]  sstart_q;
   reg [8:0]  jump_q;
   reg [15:0] sdata_q;
   reg        xfer_done_q;
   reg [2:0]  s_in1_q;
   reg [2:0]  s_in2_q;
   reg [2:0]  s_in3_q;
   reg [2:0]  s_held_q;
   wire [15:0] sio_rd;
   wire [8:0]  sptr;
   wire        sblocked;
   wire        phase_end = (cnt_q == PHASE[7:0] - 8'h01);

   // Select pin level for each cycle kind
   function sel_level;
      input [2:0] c;
      begin
         case (c)
            // block write asks for select high
            `VDC_CYC_BLKWR: sel_level = 1'b1;
            // no-reset refresh high, optional reset low
            `VDC_CYC_HREF_NR: sel_level = 1'b1;
            `VDC_CYC_SET_COL: sel_level = 1'b1;
            default: sel_level = 1'b0;
         endcase
      end
   endfunction

   // Cycle kinds with a column phase after the row; all but transfer also carry data
   function has_col;
      input [2:0] c;
      begin
         has_col = (c != `VDC_CYC_HREF_NR) && (c != `VDC_CYC_HREF_RS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register writes; a command is taken only when idle
   always @(posedge mclk) begin
      if (sys_rst) begin
         cyc_q <= `VDC_CYC_WRITE;
         late_q <= 1'b0;
         busy_q <= 1'b0;
         refused_q <= 1'b0;
         row_q <= 9'h000;
         col_q <= 9'h000;
         wdat_q <= 16'h0000;
         rev_q <= `VDC_REV_A;
         sctl_q <= 5'h00;
         sstart_q <= 9'h000;
         jump_q <= 9'h000;
         sdata_q <= 16'h0000;
      end else begin
         if (state_q == ST_DONE)
            busy_q <= 1'b0;
         if (wr_stb) begin
            case (addr)
               `VDC_OFF_CMD: begin
                  // new-mask cycle refused on revision A only
                  if (!busy_q && wr_data[`VDC_CMD_GO] &&
                      !(wr_data[2:0] == `VDC_CYC_NEWMASK && rev_q == `VDC_REV_A)) begin
                     cyc_q <= wr_data[2:0];
                     late_q <= wr_data[`VDC_CMD_LATE];
                     busy_q <= 1'b1;
                     refused_q <= 1'b0;
                  end else if (wr_data[`VDC_CMD_GO])
                     refused_q <= 1'b1;
               end
               `VDC_OFF_ROW: row_q <= wr_data[8:0];
               `VDC_OFF_COL: col_q <= wr_data[8:0];
               // column select data for block write goes here too
               `VDC_OFF_WDATA: wdat_q <= wr_data[15:0];
               `VDC_OFF_SCTL: begin
                  sctl_q <= wr_data[4:0];
                  rev_q <= wr_data[9:8];
               end
               `VDC_OFF_SSTART: sstart_q <= wr_data[8:0];
               `VDC_OFF_SDATA: sdata_q <= wr_data[15:0];
               // jump source only marks a blocked serial address while a split transfer is pending
               `VDC_OFF_RESTR: jump_q <= wr_data[8:0];
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Random-port strobe sequencer: setup, row low, column low, release
   always @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
         row_strobe_n_q <= 1'b1;
         col_strobe_n_q <= 1'b1;
         dram_addr_q <= 9'h000;
         bitmask_write_enable_n_q <= 1'b1;
         transfer_output_enable_n_q <= 1'b1;
         special_function_select_q <= 1'b0;
         random_data_pins_out_q <= 16'h0000;
         random_data_pins_oe_q <= 1'b0;
         rdat_q <= 16'h0000;
         xfer_done_q <= 1'b0;
      end else begin
         xfer_done_q <= 1'b0;
         cnt_q <= phase_end ? 8'h00 : cnt_q + 8'h01;
         case (state_q)
            ST_IDLE: begin
               cnt_q <= 8'h00;
               if (busy_q)
                  state_q <= ST_SETUP;
            end
            ST_SETUP: begin
               // controls settle before the row strobe falls
               special_function_select_q <= sel_level(cyc_q);
               transfer_output_enable_n_q <= (cyc_q != `VDC_CYC_XFER);
               // Late write keeps write enable high until inside the column phase
               bitmask_write_enable_n_q <= (cyc_q == `VDC_CYC_XFER) || late_q;
               // row address also refreshes during register set
               dram_addr_q <= row_q;
               if (cyc_q == `VDC_CYC_HREF_NR || cyc_q == `VDC_CYC_HREF_RS)
                  col_strobe_n_q <= 1'b0;
               if (phase_end)
                  state_q <= ST_ROW;
            end
            ST_ROW: begin
               row_strobe_n_q <= 1'b0;
               if (phase_end) begin
                  state_q <= has_col(cyc_q) ? ST_COL : ST_DONE;
                  dram_addr_q <= (cyc_q == `VDC_CYC_XFER) ? sstart_q : col_q;
                  random_data_pins_out_q <= wdat_q;
                  // Refresh has no column phase, so no data are driven
                  random_data_pins_oe_q <= has_col(cyc_q) && (cyc_q != `VDC_CYC_XFER);
               end
            end
            ST_COL: begin
               col_strobe_n_q <= 1'b0;
               // Late write drops the write enable one cycle after the column strobe,
               // so the data are taken on that edge and not on the column fall
               if (late_q && cnt_q != 8'h00)
                  bitmask_write_enable_n_q <= (cyc_q == `VDC_CYC_XFER);
               if (phase_end)
                  state_q <= ST_DONE;
            end
            ST_DONE: begin
               rdat_q <= random_data_pins_in;
               row_strobe_n_q <= 1'b1;
               col_strobe_n_q <= 1'b1;
               bitmask_write_enable_n_q <= 1'b1;
               transfer_output_enable_n_q <= 1'b1;
               random_data_pins_oe_q <= 1'b0;
               xfer_done_q <= (cyc_q == `VDC_CYC_XFER);
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Three-flop capture of serial input bits 0..2 for status
   always @(posedge mclk) begin
      if (sys_rst) begin
         s_in1_q <= 3'h0;
         s_in2_q <= 3'h0;
         s_in3_q <= 3'h0;
         s_held_q <= 3'h0;
      end else begin
         s_in1_q <= serial_data_pins_in[2:0];
         s_in2_q <= s_in1_q;
         s_in3_q <= s_in2_q;
         // Take a new value only once the last two stages agree
         if (s_in2_q == s_in3_q)
            s_held_q <= s_in3_q;
      end
   end

   // Read port; data one cycle after the strobe, unmapped reads zero
   always @(posedge mclk) begin
      if (sys_rst)
         rd_data_q <= 32'h00000000;
      else if (rd_stb) begin
         case (addr)
            `VDC_OFF_CMD: rd_data_q <= {27'h0, late_q, busy_q, cyc_q};
            `VDC_OFF_WDATA: rd_data_q <= {16'h0, rdat_q};
            `VDC_OFF_STATUS: rd_data_q <= {16'h0, sptr, 1'b0,
               s_held_q, sblocked, refused_q, busy_q};
            `VDC_OFF_SCTL: rd_data_q <= {22'h0, rev_q, 3'h0, sctl_q};
            `VDC_OFF_SSTART: rd_data_q <= {23'h0, sstart_q};
            `VDC_OFF_SDATA: rd_data_q <= {16'h0, sio_rd};
            `VDC_OFF_RESTR: rd_data_q <= {23'h0, jump_q};
            default: rd_data_q <= 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial side runs on its own, only told of transfers
   vdc_serial #(.DIV(`VDC_SDIV)) u_serial (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .run        (sctl_q[`VDC_SCTL_RUN]),
      .dir_wr     (sctl_q[`VDC_SCTL_DIR]),
      .wide       (WIDE != 0),
      .split      (sctl_q[`VDC_SCTL_SPLIT] && busy_q && cyc_q == `VDC_CYC_XFER),
      .rev_e      (sctl_q[`VDC_SCTL_REVE]),
      .split_half (sctl_q[`VDC_SCTL_HALF]),
      .start_addr (sstart_q),
      .jump_src   (jump_q),
      .xfer_done  (xfer_done_q),
      .wdata      (sdata_q),
      .sio_in     (serial_data_pins_in),
      .sclk_q     (serial_shift_clock_q),
      .senb_n_q   (serial_port_enable_n_q),
      .sio_out_q  (serial_data_pins_out_q),
      .sio_oe_q   (serial_data_pins_oe_q),
      .rdata_q    (sio_rd),
      .ptr_q      (sptr),
      .blocked_q  (sblocked)
   );
endmodule

/* verilog/vdc_serial.v */
/*
 File: serial-port sequencer of the host controller.
 Assumes: one clock mclk; the device serial port needs no random-port pins.
*/
`timescale 1ns/100ps
`include "vdc_regs.vh"
module vdc_serial #(
   parameter DIV = `VDC_SDIV
) (
   input  wire       mclk,
   input  wire       sys_rst,
   input  wire       run,
   input  wire       dir_wr,
   input  wire       wide,
   input  wire       split,
   input  wire       rev_e,
   input  wire       split_half,
   input  wire [8:0] start_addr,
   input  wire [8:0] jump_src,
   input  wire       xfer_done,
   input  wire [15:0] wdata,
   input  wire [15:0] sio_in,
   output reg        sclk_q,
   output reg        senb_n_q,
   output reg  [15:0] sio_out_q,
   output reg        sio_oe_q,
   output reg  [15:0] rdata_q,
   output reg  [8:0] ptr_q,
   output reg        blocked_q
);
   reg [7:0] div_q;
   reg       restrict_q;
   wire      tick = (div_q == DIV[7:0] - 8'h01);
   wire [8:0] last = wide ? `VDC_LAST_512 : `VDC_LAST_256;
   wire      half_of = wide ? ptr_q[8] : ptr_q[7];
   // forbidden serial addresses while a split transfer is pending
   wire      bad = restrict_q &&
      ((ptr_q == jump_src) || (ptr_q == last) || (rev_e && !dir_wr && half_of == split_half));

   ////////////////////////////////////////////////////////////////////////
   // Serial clock divider and pointer; untouched by random cycles except transfers, which reload the pointer
   always @(posedge mclk) begin
      if (sys_rst) begin
         div_q <= 8'h00;
         sclk_q <= 1'b0;
         senb_n_q <= 1'b1;
         sio_oe_q <= 1'b0;
         sio_out_q <= 16'h0000;
         rdata_q <= 16'h0000;
         ptr_q <= 9'h000;
         restrict_q <= 1'b0;
         blocked_q <= 1'b0;
      end else begin
         div_q <= tick ? 8'h00 : div_q + 8'h01;
         // restricted window opens with a split transfer, closes when done
         if (split && !xfer_done)
            restrict_q <= 1'b1;
         else if (xfer_done)
            restrict_q <= 1'b0;
         blocked_q <= bad;
         senb_n_q <= !run;
         sio_oe_q <= run && dir_wr;
         if (xfer_done)
            ptr_q <= start_addr;
         else if (tick) begin
            // Hold the clock low while blocked so no edge hits a bad address
            if (!sclk_q && run && !bad) begin
               sclk_q <= 1'b1;
               if (!dir_wr)
                  rdata_q <= sio_in;
            end else if (sclk_q) begin
               sclk_q <= 1'b0;
               sio_out_q <= wdata;
               // wrap from last address to transfer start
               ptr_q <= (ptr_q == last) ? start_addr : ptr_q + 9'h001;
            end
         end
      end
   end
endmodule
